/* File: common/sdr_pkg.sv */
// How it works
// R1: Pin level bits mirror each I/O pin, 1 high; cleared by reset, and by read only while low-power-off mode is active.
// R2: Pin level bits hold their value while low-power-off mode is active, except when a read clears them.
// R3: Pre-regulator byte: boost bit7 down to current limit bit1, bit0 zero.
// R4: Boost mode bit follows the regulator mode, resets to 0, survives reads.
// R5: Pre-regulator on bit follows the regulator, resets to 1, survives reads.
// R6: Pre-regulator thermal warning latches high, cleared by reset or read.
// R7: Pre-regulator thermal shutdown latches high, cleared by reset or read.
// R8: Pre-regulator overvoltage latches high, cleared by reset or read.
// R9: Pre-regulator undervoltage latches high, resets to 1, cleared by read.
// R10: Pre-regulator current limit latches high, cleared by reset or read.
// R11: Core byte: on state bit6 to feedback undervoltage bit2; bits 7,1,0 zero.
// R12: Core on bit follows the core regulator, resets to 1, survives reads.
// R13: Read clear lands at frame end; a live or new event sets again.
// R14: Host reads with a 16-bit frame: command and address high, zero low.
package sdr_pkg;
  localparam int          FRAME_BITS     = 16;
  localparam int          BIT_CNT_W      = 4;
  localparam logic [7:0]  ADDR_IO_LEVEL  = 8'h16;
  localparam logic [7:0]  ADDR_PRE_DIAG  = 8'h18;
  localparam logic [7:0]  ADDR_CORE_DIAG = 8'h1A;
  localparam int          IO_COUNT       = 5;
  // Pin level byte positions, pins 5,4,3,2,0
  localparam int          IO5_POS        = 7;
  localparam int          IO4_POS        = 6;
  localparam int          IO3_POS        = 4;
  localparam int          IO2_POS        = 3;
  localparam int          IO0_POS        = 0;
  localparam int          PRE_BOOST_POS  = 7;
  localparam int          PRE_ON_POS     = 6;
  localparam int          PRE_TWARN_POS  = 5;
  localparam int          PRE_TSD_POS    = 4;
  localparam int          PRE_OV_POS     = 3;
  localparam int          PRE_UV_POS     = 2;
  localparam int          PRE_ILIM_POS   = 1;
  localparam int          CORE_ON_POS    = 6;
  localparam int          CORE_TWARN_POS = 5;
  localparam int          CORE_TSD_POS   = 4;
  localparam int          CORE_OV_POS    = 3;
  localparam int          CORE_UV_POS    = 2;
  localparam logic [4:0]  IO_RESET       = 5'h0;
  localparam logic        BOOST_RESET    = 1'b0;
  localparam logic        PRE_ON_RESET   = 1'b1;
  localparam logic        CORE_ON_RESET  = 1'b1;
  // Pre flags {twarn,tsd,ov,uv,ilim}; core flags {twarn,tsd,ov,uv}
  localparam logic [4:0]  PRE_FLAG_RESET = 5'h02;
  localparam logic [3:0]  CORE_FLAG_RST  = 4'h1;
  localparam int          SUMMARY_PRE    = 10;
  localparam int          SUMMARY_CORE   = 9;
endpackage

/* File: hdl/sdr_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module sdr_flag #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         MCLK,
  input  wire logic         SYS_RST,
  input  wire logic         CLK_EN,
  input  wire logic [W-1:0] ev,
  input  wire logic         clr,
  output logic [W-1:0]      flag_q
);
  logic [W-1:0] flag_d;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      // Set wins over the frame-end clear so no event is lost
      always_comb
      begin
        flag_d[i] = (clr ? 1'b0 : flag_q[i]) | ev[i]; // R13
      end
    end
  endgenerate

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      flag_q <= RST;
    else if (CLK_EN)
      flag_q <= flag_d;
  end
endmodule
`default_nettype wire

/* File: hdl/sdr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sdr_top (
  input  wire logic       MCLK,
  input  wire logic       SYS_RST,
  input  wire logic       CLK_EN,
  input  wire logic       SPI_CS_N,
  input  wire logic       SPI_SCLK,
  input  wire logic       SPI_MOSI,
  output logic            SPI_MISO,
  input  wire logic [4:0] IO_PIN_LEVEL,
  input  wire logic       LOW_POWER_OFF_MODE,
  input  wire logic       PREREG_BOOST_MODE,
  input  wire logic       PREREG_ON_STATE,
  input  wire logic       PREREG_THERMAL_WARNING,
  input  wire logic       PREREG_THERMAL_SHUTDOWN,
  input  wire logic       PREREG_OVERVOLTAGE,
  input  wire logic       PREREG_UNDERVOLTAGE,
  input  wire logic       PREREG_CURRENT_LIMIT,
  input  wire logic       CORE_REG_ON_STATE,
  input  wire logic       CORE_REG_THERMAL_WARNING,
  input  wire logic       CORE_REG_THERMAL_SHUTDOWN,
  input  wire logic       CORE_FEEDBACK_OVERVOLTAGE,
  input  wire logic       CORE_FEEDBACK_UNDERVOLTAGE
);
  // ------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------
  // SCLK is oversampled on MCLK; SPI mode 0, MSB first.
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} sdr_state_t;

  sdr_state_t                      state_q, state_d;
  logic                            sclk_q, sclk_d;
  logic [sdr_pkg::BIT_CNT_W-1:0]   cnt_q, cnt_d;
  logic [sdr_pkg::FRAME_BITS-1:0]  rx_q, rx_d;
  logic [sdr_pkg::FRAME_BITS-1:0]  tx_q, tx_d;
  logic [7:0]                      addr_q, addr_d;
  logic                            miso_q, miso_d;
  logic                            rise, fall;
  logic [sdr_pkg::FRAME_BITS-1:0]  resp;
  logic                            frame_end;
  logic                            clr_io, clr_pre, clr_core;
  logic                            snap;

  // ------------------------------------------------------------
  // Register contents
  // ------------------------------------------------------------
  logic [4:0] io_q, io_d;
  logic       boost_q, boost_d, pre_on_q, pre_on_d, core_on_q, core_on_d;
  logic [4:0] pre_flags;
  logic [3:0] core_flags;
  logic [7:0] io_byte, pre_byte, core_byte;
  logic [4:0] pre_ev, pre_set, pre_seen_q, pre_seen_d;
  logic [3:0] core_ev, core_set, core_seen_q, core_seen_d;

  assign rise = SPI_SCLK & ~sclk_q;
  assign fall = ~SPI_SCLK & sclk_q;

  // Response header: summary bits flag any latched diagnostic
  always_comb
  begin
    resp = '0;
    resp[sdr_pkg::SUMMARY_PRE]  = |pre_flags;
    resp[sdr_pkg::SUMMARY_CORE] = |core_flags;
    case (rx_q[6:0])
      sdr_pkg::ADDR_IO_LEVEL[7:1]:  resp[7:0] = io_byte;
      sdr_pkg::ADDR_PRE_DIAG[7:1]:  resp[7:0] = pre_byte;
      sdr_pkg::ADDR_CORE_DIAG[7:1]: resp[7:0] = core_byte;
      default:                      resp[7:0] = 8'h00;
    endcase
  end

  always_comb
  begin
    state_d   = state_q;
    sclk_d    = SPI_SCLK;
    cnt_d     = cnt_q;
    rx_d      = rx_q;
    tx_d      = tx_q;
    addr_d    = addr_q;
    miso_d    = miso_q;
    frame_end = 1'b0;
    snap      = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        cnt_d  = '0;
        miso_d = 1'b0;
        if (!SPI_CS_N)
          state_d = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        if (SPI_CS_N)
          state_d = ST_IDLE;
        else
        begin
          if (rise)
          begin
            rx_d  = {rx_q[14:0], SPI_MOSI};
            cnt_d = cnt_q + 4'h1;
            // After the address byte, latch the reply for the low byte
            if (cnt_q == 4'h7)
            begin
              addr_d = {rx_q[6:0], SPI_MOSI};
              tx_d   = resp;
              snap   = 1'b1;
            end
            if (cnt_q == 4'hF)
              state_d = ST_DONE;
          end
          if (fall)
          begin
            miso_d = tx_q[~cnt_q];
          end
        end
      end
      ST_DONE:
      begin
        if (SPI_CS_N)
        begin
          frame_end = 1'b1;
          state_d   = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Host sends address then zero byte; read command bit is ignored here
  assign clr_io   = frame_end & (addr_q[7:1] == sdr_pkg::ADDR_IO_LEVEL[7:1]);  // R14
  assign clr_pre  = frame_end & (addr_q[7:1] == sdr_pkg::ADDR_PRE_DIAG[7:1]);  // R13
  assign clr_core = frame_end & (addr_q[7:1] == sdr_pkg::ADDR_CORE_DIAG[7:1]); // R13

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      state_q <= ST_IDLE;
      sclk_q  <= 1'b0;
      cnt_q   <= '0;
      rx_q    <= '0;
      tx_q    <= '0;
      addr_q  <= 8'h00;
      miso_q  <= 1'b0;
    end
    else if (CLK_EN)
    begin
      state_q <= state_d;
      sclk_q  <= sclk_d;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      addr_q  <= addr_d;
      miso_q  <= miso_d;
    end
  end

  assign SPI_MISO = miso_q;

  // ------------------------------------------------------------
  // Pin level and state bits
  // ------------------------------------------------------------
  always_comb
  begin
    io_d = io_q;
    if (clr_io)
      io_d = '0; // R1
    if (!LOW_POWER_OFF_MODE)
      io_d = IO_PIN_LEVEL; // R1
    else if (!clr_io)
      io_d = io_q; // R2
    boost_d   = PREREG_BOOST_MODE; // R4
    pre_on_d  = PREREG_ON_STATE;   // R5
    core_on_d = CORE_REG_ON_STATE; // R12
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      io_q      <= sdr_pkg::IO_RESET;
      boost_q   <= sdr_pkg::BOOST_RESET;
      pre_on_q  <= sdr_pkg::PRE_ON_RESET;
      core_on_q <= sdr_pkg::CORE_ON_RESET;
    end
    else if (CLK_EN)
    begin
      io_q      <= io_d;
      boost_q   <= boost_d;
      pre_on_q  <= pre_on_d;
      core_on_q <= core_on_d;
    end
  end

  // ------------------------------------------------------------
  // Latched fault flags
  // ------------------------------------------------------------
  assign pre_ev  = {PREREG_THERMAL_WARNING, PREREG_THERMAL_SHUTDOWN, PREREG_OVERVOLTAGE,
                    PREREG_UNDERVOLTAGE, PREREG_CURRENT_LIMIT}; // R6 R7 R8 R9 R10
  assign core_ev = {CORE_REG_THERMAL_WARNING, CORE_REG_THERMAL_SHUTDOWN,
                    CORE_FEEDBACK_OVERVOLTAGE, CORE_FEEDBACK_UNDERVOLTAGE}; // R11

  // An event newer than the captured reply was never reported, so it is
  // raised again in the cycle the read clear lands
  always_comb
  begin
    pre_seen_d  = snap ? pre_ev : (pre_seen_q | pre_ev);
    core_seen_d = snap ? core_ev : (core_seen_q | core_ev);
    pre_set     = pre_ev | (pre_seen_q & {5{clr_pre}});    // R13
    core_set    = core_ev | (core_seen_q & {4{clr_core}}); // R13
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      pre_seen_q  <= 5'h0;
      core_seen_q <= 4'h0;
    end
    else if (CLK_EN)
    begin
      pre_seen_q  <= pre_seen_d;
      core_seen_q <= core_seen_d;
    end
  end

  sdr_flag #(.W(5), .RST(sdr_pkg::PRE_FLAG_RESET)) u_pre (
    .MCLK    (MCLK),
    .SYS_RST (SYS_RST),
    .CLK_EN  (CLK_EN),
    .ev      (pre_set),
    .clr     (clr_pre),
    .flag_q  (pre_flags)
  );

  sdr_flag #(.W(4), .RST(sdr_pkg::CORE_FLAG_RST)) u_core (
    .MCLK    (MCLK),
    .SYS_RST (SYS_RST),
    .CLK_EN  (CLK_EN),
    .ev      (core_set), // R11
    .clr     (clr_core),
    .flag_q  (core_flags)
  );

  always_comb
  begin
    io_byte = 8'h00;
    io_byte[sdr_pkg::IO5_POS] = io_q[4];
    io_byte[sdr_pkg::IO4_POS] = io_q[3];
    io_byte[sdr_pkg::IO3_POS] = io_q[2];
    io_byte[sdr_pkg::IO2_POS] = io_q[1];
    io_byte[sdr_pkg::IO0_POS] = io_q[0];
    pre_byte = 8'h00; // R3
    pre_byte[sdr_pkg::PRE_BOOST_POS] = boost_q;
    pre_byte[sdr_pkg::PRE_ON_POS]    = pre_on_q;
    pre_byte[sdr_pkg::PRE_TWARN_POS] = pre_flags[4];
    pre_byte[sdr_pkg::PRE_TSD_POS]   = pre_flags[3];
    pre_byte[sdr_pkg::PRE_OV_POS]    = pre_flags[2];
    pre_byte[sdr_pkg::PRE_UV_POS]    = pre_flags[1];
    pre_byte[sdr_pkg::PRE_ILIM_POS]  = pre_flags[0];
    core_byte = 8'h00; // R11
    core_byte[sdr_pkg::CORE_ON_POS]    = core_on_q;
    core_byte[sdr_pkg::CORE_TWARN_POS] = core_flags[3];
    core_byte[sdr_pkg::CORE_TSD_POS]   = core_flags[2];
    core_byte[sdr_pkg::CORE_OV_POS]    = core_flags[1];
    core_byte[sdr_pkg::CORE_UV_POS]    = core_flags[0];
  end
endmodule
`default_nettype wire

/* File: tb/sdr_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sdr_props (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic SPI_CS_N,
  input wire logic SPI_SCLK,
  input wire logic SPI_MOSI,
  input wire logic SPI_MISO,
  input wire logic PREREG_BOOST_MODE,
  input wire logic PREREG_ON_STATE,
  input wire logic CORE_REG_ON_STATE
);
  // ----
  // Frame tracker
  // ----
  logic        sclk_q, cs_q, held_q, rise, fend;
  logic [4:0]  cnt_q;
  logic [15:0] mosi_q, rx_q;
  logic [6:0]  adr;
  assign rise = SPI_SCLK && !sclk_q;
  assign fend = SPI_CS_N && !cs_q && cnt_q == 5'h10;
  assign adr = mosi_q[15:9];
  always_ff @(posedge MCLK)
  begin
    sclk_q <= SPI_SCLK;
    cs_q <= SPI_CS_N;
    // State inputs must hold for the whole frame, else the reply may show either value
    held_q <= SPI_CS_N || (held_q && $stable(PREREG_BOOST_MODE) && $stable(PREREG_ON_STATE)
              && $stable(CORE_REG_ON_STATE));
    cnt_q <= SPI_CS_N ? 5'h00 : cnt_q + {4'h0, rise};
    if (rise)
    begin
      mosi_q <= {mosi_q[14:0], SPI_MOSI};
      rx_q <= {rx_q[14:0], SPI_MISO};
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  sequence end_pin; fend && adr == sdr_pkg::ADDR_IO_LEVEL[7:1]; endsequence
  sequence end_pre; fend && adr == sdr_pkg::ADDR_PRE_DIAG[7:1]; endsequence
  sequence end_core; fend && adr == sdr_pkg::ADDR_CORE_DIAG[7:1]; endsequence
  // ----
  // Checks
  // ----
  pin_pad_zero_a: assert property (end_pin |-> !rx_q[5] && rx_q[2:1] == 2'h0)
    else $error("pin reply padding not zero");
  pre_pad_zero_a: assert property (end_pre |-> !rx_q[0])
    else $error("pre reply bit0 not zero");
  core_pad_zero_a: assert property (end_core |-> !rx_q[7] && rx_q[1:0] == 2'h0)
    else $error("core reply padding not zero");
  pre_state_a: assert property (end_pre ##0 held_q |->
    rx_q[7] == PREREG_BOOST_MODE && rx_q[6] == PREREG_ON_STATE) else $error("pre state bits");
  core_state_a: assert property (end_core ##0 held_q |-> rx_q[6] == CORE_REG_ON_STATE)
    else $error("core state bit");
  unknown_zero_a: assert property (fend && adr > 7'h0D |-> rx_q[7:0] == 8'h00)
    else $error("unknown address reply not zero");
  miso_stands_a: assert property (SPI_SCLK [*3] |-> $stable(SPI_MISO))
    else $error("data out moved while clock high");
  freeze_hold_a: assert property (!CLK_EN |=> $stable(SPI_MISO))
    else $error("data out moved while frozen");
  miso_reset_a: assert property (disable iff (1'b0) SYS_RST && CLK_EN |=> !SPI_MISO)
    else $error("data out not low after reset");
endmodule
bind sdr_top sdr_props chk_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
  .SPI_CS_N(SPI_CS_N), .SPI_SCLK(SPI_SCLK), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO),
  .PREREG_BOOST_MODE(PREREG_BOOST_MODE), .PREREG_ON_STATE(PREREG_ON_STATE),
  .CORE_REG_ON_STATE(CORE_REG_ON_STATE));
`default_nettype wire

/* File: tb/sdr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sdr_host (
  input  wire logic MCLK,
  input  wire logic SPI_MISO,
  output var logic  SPI_CS_N,
  output var logic  SPI_SCLK,
  output var logic  SPI_MOSI
);
  // ----
  // Host read frame, mode 0
  // ----
  int half = 3;
  initial
  begin
    SPI_CS_N = 1'b1;
    SPI_SCLK = 1'b0;
    SPI_MOSI = 1'b0;
  end
  task automatic read(input logic [7:0] adr, output logic [7:0] dat);
    logic [15:0] tx;
    logic [15:0] rx;
    tx = {adr, 8'h00};
    rx = 16'h0000;
    @(posedge MCLK);
    SPI_CS_N <= 1'b0;
    SPI_MOSI <= tx[15];
    for (int i = 0; i < 16; i++)
    begin
      repeat (half) @(posedge MCLK);
      SPI_SCLK <= 1'b1;
      rx = {rx[14:0], SPI_MISO};
      repeat (half) @(posedge MCLK);
      SPI_SCLK <= 1'b0;
      // After the last bit the line is released; inverting it exposes stale sampling
      SPI_MOSI <= (i < 15) ? tx[14 - i] : ~tx[0];
    end
    repeat (half) @(posedge MCLK);
    SPI_CS_N <= 1'b1;
    dat = rx[7:0];
    repeat (half) @(posedge MCLK);
  endtask
endmodule
`default_nettype wire

/* File: tb/supply_diag_status_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module supply_diag_status_regs_bench;
  localparam logic [7:0] PIN = sdr_pkg::ADDR_IO_LEVEL;
  localparam logic [7:0] PRE = sdr_pkg::ADDR_PRE_DIAG;
  localparam logic [7:0] COR = sdr_pkg::ADDR_CORE_DIAG;
  logic       mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, low_power_off_mode = 1'b0;
  logic       boost = 1'b0, pre_on = 1'b1, core_on = 1'b1;
  logic       cs_n, sclk, mosi, miso;
  logic [4:0] pins = 5'h00, pre_ev = 5'h00;
  logic [3:0] core_ev = 4'h0;
  int         fail_count = 0, compares = 0;
  always #10 mclk = ~mclk;
  sdr_host host_u (.MCLK(mclk), .SPI_MISO(miso), .SPI_CS_N(cs_n), .SPI_SCLK(sclk),
    .SPI_MOSI(mosi));
  sdr_top dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .CLK_EN(clk_en), .SPI_CS_N(cs_n),
    .SPI_SCLK(sclk), .SPI_MOSI(mosi), .SPI_MISO(miso), .IO_PIN_LEVEL(pins),
    .LOW_POWER_OFF_MODE(low_power_off_mode), .PREREG_BOOST_MODE(boost), .PREREG_ON_STATE(pre_on),
    .PREREG_THERMAL_WARNING(pre_ev[4]), .PREREG_THERMAL_SHUTDOWN(pre_ev[3]),
    .PREREG_OVERVOLTAGE(pre_ev[2]), .PREREG_UNDERVOLTAGE(pre_ev[1]),
    .PREREG_CURRENT_LIMIT(pre_ev[0]), .CORE_REG_ON_STATE(core_on),
    .CORE_REG_THERMAL_WARNING(core_ev[3]), .CORE_REG_THERMAL_SHUTDOWN(core_ev[2]),
    .CORE_FEEDBACK_OVERVOLTAGE(core_ev[1]), .CORE_FEEDBACK_UNDERVOLTAGE(core_ev[0]));
  // ----
  // Tasks
  // ----
  task check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task rd(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] d;
    host_u.read(adr, d);
    check8(d, exp);
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    tick(20000);
    fail_count++;
    give_verdict;
  end
  // ----
  // Scenarios
  // ----
  initial
  begin
    tick(8);
    sys_rst <= 1'b0;
    tick(1);
    rd(PRE, 8'h44);
    rd(PRE, 8'h40);
    rd(COR, 8'h44);
    rd(COR, 8'h40);
    for (int i = 0; i < 5; i++)
    begin
      pre_ev <= 5'h01 << i;
      tick(1);
      pre_ev <= 5'h00;
      rd(PRE, 8'h40 | {2'h0, 5'h01 << i, 1'b0});
      rd(PRE, 8'h40);
    end
    for (int i = 0; i < 4; i++)
    begin
      core_ev <= 4'h1 << i;
      tick(1);
      core_ev <= 4'h0;
      rd(COR, 8'h40 | {2'h0, 4'h1 << i, 2'h0});
      rd(COR, 8'h40);
    end
    boost <= 1'b1;
    pre_on <= 1'b0;
    core_on <= 1'b0;
    rd(PRE, 8'h80);
    rd(PRE, 8'h80);
    rd(COR, 8'h00);
    boost <= 1'b0;
    pre_on <= 1'b1;
    core_on <= 1'b1;
    // Event still live across a slow frame must survive the clear
    host_u.half = 6;
    pre_ev <= 5'h04;
    rd(PRE, 8'h48);
    pre_ev <= 5'h00;
    rd(PRE, 8'h48);
    rd(PRE, 8'h40);
    host_u.half = 3;
    // A fault that comes and goes after the reply is captured must not be lost
    fork
      rd(PRE, 8'h40);
      begin
        tick(60);
        pre_ev <= 5'h10;
        tick(1);
        pre_ev <= 5'h00;
      end
    join
    rd(PRE, 8'h60);
    rd(PRE, 8'h40);
    pins <= 5'h16;
    tick(2);
    rd(PIN, 8'h98);
    low_power_off_mode <= 1'b1;
    tick(2);
    pins <= 5'h09;
    tick(2);
    rd(PIN, 8'h98);
    rd(PIN, 8'h00);
    low_power_off_mode <= 1'b0;
    tick(2);
    rd(PIN, 8'h41);
    clk_en <= 1'b0;
    pre_ev <= 5'h10;
    tick(3);
    pre_ev <= 5'h00;
    clk_en <= 1'b1;
    rd(PRE, 8'h40);
    rd(8'h1C, 8'h00);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    tick(1);
    rd(PRE, 8'h44);
    give_verdict;
  end
endmodule
`default_nettype wire
